// ==== lowrate_pkg.sv ====
// constants, types and the per-band peak and magnitude accumulator
// How it works
// [R1] SWB/FB at 13.2/16.4 picks Transient, Normal, Harmonic
// [R2] 8/16 kHz input skips sharpness, Transient or Normal
// [R3] two mode bits: transient flag, harmonic flag
// [R4] NB and WB non-transient frames always Normal
// [R5] SWB/FB low rates split Normal/Harmonic by sharpness
// [R6] 448 coefficients, fourteen 32-wide bands, indices 3-16
// [R7] sharpness is 32*peak/sum, zero for zero sum
// [R8] band peak is largest absolute coefficient
// [R9] low tally counts bands 3-7 sharper than 4.5
// [R10] high tally: bands 8-16, sharpness>3.6, peak>10
// [R11] tally hit raises harmonic, lowers non-harmonic counter
// [R12] counters start zero, saturate between 0 and 8
// [R13] harmonic if nonharm<5 with hit, or harm>=5
// [R14] layout: NB, WB, SWB shared by SWB and FB
// [R15] FB uses exactly the SWB band layout
// [R16] transient: four sub-transforms joined back to back
// [R17] counters kept across frames, decided once per frame
`timescale 1ns/1ps

package lowrate_pkg;
	localparam int COEF_W = 16;
	localparam int ABS_W = 16;
	localparam int SUM_W = 21;
	localparam int CMP_W = 26;
	localparam int BAND_LEN = 32;
	localparam int POS_W = 5;
	localparam logic [POS_W-1:0] POS_LAST = 5'h1f;
	localparam int BAND_W = 5;
	localparam logic [BAND_W-1:0] FIRST_BAND = 5'h03;
	localparam logic [BAND_W-1:0] LAST_LOW_BAND = 5'h07;
	localparam logic [BAND_W-1:0] LAST_BAND = 5'h10;
	// 32*peak/sum > 4.5  <=>  64*peak > 9*sum
	localparam logic [CMP_W-1:0] LOW_PEAK_MUL = 26'h0000040;
	localparam logic [CMP_W-1:0] LOW_SUM_MUL = 26'h0000009;
	// 32*peak/sum > 3.6  <=>  80*peak > 9*sum
	localparam logic [CMP_W-1:0] HIGH_PEAK_MUL = 26'h0000050;
	localparam logic [CMP_W-1:0] HIGH_SUM_MUL = 26'h0000009;
	localparam logic [ABS_W-1:0] HIGH_PEAK_MIN = 16'h000a;
	localparam int TALLY_W = 4;
	localparam logic [TALLY_W-1:0] TALLY_SUM_MIN = 4'ha;
	localparam logic [TALLY_W-1:0] HIGH_TALLY_MIN = 4'h5;
	localparam int PERSIST_W = 4;
	localparam logic [PERSIST_W-1:0] PERSIST_MAX = 4'h8;
	localparam logic [PERSIST_W-1:0] PERSIST_ZERO = 4'h0;
	localparam logic [PERSIST_W-1:0] PERSIST_HARM = 4'h5;
	localparam int IDX_W = 10;
	localparam int SUB_W = 8;
	localparam logic [IDX_W-1:0] SUB_LEN_NB = 10'h028;
	localparam logic [IDX_W-1:0] SUB_LEN_WB = 10'h050;
	localparam logic [IDX_W-1:0] SUB_LEN_SWB = 10'h0a0;

	typedef enum logic [1:0] {
		bw_nb = 2'h0,
		bw_wb = 2'h1,
		bw_swb = 2'h2,
		bw_fb = 2'h3
	} bandwidth_type;

	typedef enum logic [1:0] {
		rate_7k2 = 2'h0,
		rate_8k = 2'h1,
		rate_13k2 = 2'h2,
		rate_16k4 = 2'h3
	} rate_type;

	typedef enum logic [1:0] {
		layout_nb = 2'h0,
		layout_wb = 2'h1,
		layout_swb = 2'h2
	} layout_type;
endpackage

module band_peak_accum (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// restart at the head of a frame
	input wire logic clear,
	// coefficient stream
	input wire logic coef_valid,
	input wire logic signed [lowrate_pkg::COEF_W-1:0] coef_data,
	// one band finished
	output logic band_done,
	output logic [lowrate_pkg::ABS_W-1:0] band_peak,
	output logic [lowrate_pkg::SUM_W-1:0] band_sum
);
	logic [lowrate_pkg::POS_W-1:0] pos_reg;
	logic [lowrate_pkg::ABS_W-1:0] peak_reg;
	logic [lowrate_pkg::SUM_W-1:0] sum_reg;
	wire [lowrate_pkg::ABS_W-1:0] mag;
	wire [lowrate_pkg::ABS_W-1:0] peak_next;
	wire [lowrate_pkg::SUM_W-1:0] sum_next;
	wire last_of_band;

	// unsigned view keeps the most negative value as its true magnitude
	assign mag = coef_data[lowrate_pkg::COEF_W-1] ?
		lowrate_pkg::ABS_W'(-coef_data) : lowrate_pkg::ABS_W'(coef_data);
	assign peak_next = (mag > peak_reg) ? mag : peak_reg; // [R8]
	assign sum_next = sum_reg + lowrate_pkg::SUM_W'(mag);
	assign last_of_band = coef_valid && (pos_reg == lowrate_pkg::POS_LAST);

	always_ff @(posedge mclk) begin
		if (reset || clear) begin
			pos_reg <= '0;
			peak_reg <= '0;
			sum_reg <= '0;
		end else if (coef_valid) begin
			pos_reg <= pos_reg + 1'b1; // [R6]
			peak_reg <= last_of_band ? '0 : peak_next;
			sum_reg <= last_of_band ? '0 : sum_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset || clear) begin
			band_done <= 1'b0;
			band_peak <= '0;
			band_sum <= '0;
		end else begin
			band_done <= last_of_band;
			if (last_of_band) begin
				band_peak <= peak_next;
				band_sum <= sum_next;
			end
		end
	end

	peak_within_sum_a: assert property (@(posedge mclk) disable iff (reset)
		band_done |-> band_peak <= band_sum) // [R8]
		else $error("band peak exceeds band magnitude sum");
	band_spacing_a: assert property (@(posedge mclk) disable iff (reset)
		band_done |=> !band_done [*8]) // [R6]
		else $error("bands finished closer than 32 coefficients");
endmodule

// ==== lowrate_mode_classifier.sv ====
// frame mode decision, sharpness tallies and band layout selection
`timescale 1ns/1ps

module lowrate_mode_classifier (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// frame settings, taken with frame_start
	input wire logic frame_start,
	input wire logic [1:0] frame_bandwidth,
	input wire logic [1:0] frame_rate,
	input wire logic frame_transient,
	// classifier coefficients, bands 3 to 16 in order
	input wire logic coef_valid,
	input wire logic signed [lowrate_pkg::COEF_W-1:0] coef_data,
	// sub-transform coefficient position
	input wire logic sub_valid,
	input wire logic [1:0] sub_index,
	input wire logic [lowrate_pkg::SUB_W-1:0] sub_coef_index,
	// mode decision
	output logic mode_valid,
	output logic mode_transient,
	output logic mode_harmonic,
	output logic [1:0] layout_sel,
	output logic classify_busy,
	// persistence state
	output logic [lowrate_pkg::PERSIST_W-1:0] harmonic_persist_ctr,
	output logic [lowrate_pkg::PERSIST_W-1:0] nonharmonic_persist_ctr,
	// grouped coefficient position
	output logic concat_valid,
	output logic [lowrate_pkg::IDX_W-1:0] concat_index
);
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_collect = 3'b010,
		st_decide = 3'b100
	} state_type;

	state_type state_reg;
	state_type state_next;

	logic [1:0] bw_reg;
	logic [1:0] rate_reg;
	logic transient_reg;
	logic [lowrate_pkg::BAND_W-1:0] band_reg;
	logic [lowrate_pkg::TALLY_W-1:0] low_tally_reg;
	logic [lowrate_pkg::TALLY_W-1:0] high_tally_reg;
	logic [lowrate_pkg::PERSIST_W-1:0] harm_ctr_reg;
	logic [lowrate_pkg::PERSIST_W-1:0] nonharm_ctr_reg;
	logic [lowrate_pkg::PERSIST_W-1:0] harm_ctr_next;
	logic [lowrate_pkg::PERSIST_W-1:0] nonharm_ctr_next;
	logic bypass_reg;

	wire band_done;
	wire [lowrate_pkg::ABS_W-1:0] band_peak;
	wire [lowrate_pkg::SUM_W-1:0] band_sum;

	// layout family for a bandwidth code; FB folds onto SWB
	function automatic logic [1:0] layout_of(input logic [1:0] bw);
		logic [1:0] sel;
		sel = lowrate_pkg::layout_swb;
		if (bw == lowrate_pkg::bw_nb) begin
			sel = lowrate_pkg::layout_nb;
		end else if (bw == lowrate_pkg::bw_wb) begin
			sel = lowrate_pkg::layout_wb;
		end
		return sel;
	endfunction

	// true when a frame may go through the sharpness split
	function automatic logic split_allowed(input logic [1:0] bw,
		input logic [1:0] rate);
		logic hi_bw;
		logic hi_rate;
		hi_bw = (bw == lowrate_pkg::bw_swb) || (bw == lowrate_pkg::bw_fb);
		hi_rate = (rate == lowrate_pkg::rate_13k2) ||
			(rate == lowrate_pkg::rate_16k4);
		return hi_bw && hi_rate;
	endfunction

	band_peak_accum accum (
		.mclk(mclk),
		.reset(reset),
		.clear(frame_start),
		.coef_valid(coef_valid && (state_reg == st_collect)),
		.coef_data(coef_data),
		.band_done(band_done),
		.band_peak(band_peak),
		.band_sum(band_sum)
	);

	// sharpness compare done on cross-multiplied integers, no divider
	wire [lowrate_pkg::CMP_W-1:0] peak_wide;
	wire [lowrate_pkg::CMP_W-1:0] sum_wide;
	wire sum_nonzero;
	wire low_sharp;
	wire high_sharp;
	wire in_low_range;
	wire in_high_range;
	wire last_band;

	assign peak_wide = lowrate_pkg::CMP_W'(band_peak);
	assign sum_wide = lowrate_pkg::CMP_W'(band_sum);
	assign sum_nonzero = (band_sum != '0); // [R7]
	assign low_sharp = sum_nonzero &&
		(lowrate_pkg::CMP_W'(peak_wide * lowrate_pkg::LOW_PEAK_MUL) >
		lowrate_pkg::CMP_W'(sum_wide * lowrate_pkg::LOW_SUM_MUL)); // [R7]
	assign high_sharp = sum_nonzero &&
		(lowrate_pkg::CMP_W'(peak_wide * lowrate_pkg::HIGH_PEAK_MUL) >
		lowrate_pkg::CMP_W'(sum_wide * lowrate_pkg::HIGH_SUM_MUL)); // [R7]
	assign in_low_range = (band_reg <= lowrate_pkg::LAST_LOW_BAND);
	assign in_high_range = !in_low_range;
	assign last_band = (band_reg == lowrate_pkg::LAST_BAND);

	// persistence update from the finished tallies
	wire [lowrate_pkg::TALLY_W-1:0] tally_sum;
	wire tally_hit;
	wire harm_full;
	wire harm_empty;
	wire nonharm_full;
	wire nonharm_empty;
	wire frame_harmonic;

	assign tally_sum = low_tally_reg + high_tally_reg;
	assign tally_hit = (tally_sum >= lowrate_pkg::TALLY_SUM_MIN) &&
		(high_tally_reg > lowrate_pkg::HIGH_TALLY_MIN); // [R11]
	assign harm_full = (harm_ctr_reg == lowrate_pkg::PERSIST_MAX);
	assign harm_empty = (harm_ctr_reg == lowrate_pkg::PERSIST_ZERO);
	assign nonharm_full = (nonharm_ctr_reg == lowrate_pkg::PERSIST_MAX);
	assign nonharm_empty = (nonharm_ctr_reg == lowrate_pkg::PERSIST_ZERO);

	always_comb begin
		harm_ctr_next = harm_ctr_reg;
		nonharm_ctr_next = nonharm_ctr_reg;
		if (tally_hit) begin
			if (!harm_full) begin
				harm_ctr_next = harm_ctr_reg + 1'b1; // [R11] [R12]
			end
			if (!nonharm_empty) begin
				nonharm_ctr_next = nonharm_ctr_reg - 1'b1; // [R11] [R12]
			end
		end else begin
			if (!harm_empty) begin
				harm_ctr_next = harm_ctr_reg - 1'b1; // [R11] [R12]
			end
			if (!nonharm_full) begin
				nonharm_ctr_next = nonharm_ctr_reg + 1'b1; // [R11] [R12]
			end
		end
	end

	// decision reads the counters as updated by this frame
	assign frame_harmonic =
		((nonharm_ctr_next < lowrate_pkg::PERSIST_HARM) && tally_hit) ||
		(harm_ctr_next >= lowrate_pkg::PERSIST_HARM); // [R13]

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			st_idle: begin
				if (frame_start && !frame_transient &&
					split_allowed(frame_bandwidth, frame_rate)) begin
					state_next = st_collect; // [R1] [R5]
				end
			end
			st_collect: begin
				if (frame_start) begin
					state_next = st_idle;
				end else if (band_done && last_band) begin
					state_next = st_decide; // [R17]
				end
			end
			st_decide: begin
				state_next = st_idle;
			end
			default: begin
				state_next = st_idle;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= st_idle;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			bw_reg <= lowrate_pkg::bw_nb;
			rate_reg <= lowrate_pkg::rate_7k2;
			transient_reg <= 1'b0;
			bypass_reg <= 1'b0;
		end else begin
			bypass_reg <= frame_start && (frame_transient ||
				!split_allowed(frame_bandwidth, frame_rate)); // [R2] [R4]
			if (frame_start) begin
				bw_reg <= frame_bandwidth;
				rate_reg <= frame_rate;
				transient_reg <= frame_transient;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset || frame_start) begin
			band_reg <= lowrate_pkg::FIRST_BAND; // [R6]
			low_tally_reg <= '0; // [R9]
			high_tally_reg <= '0; // [R10]
		end else if (band_done && state_reg == st_collect) begin
			band_reg <= band_reg + 1'b1;
			if (in_low_range && low_sharp) begin
				low_tally_reg <= low_tally_reg + 1'b1; // [R9]
			end
			if (in_high_range && high_sharp &&
				band_peak > lowrate_pkg::HIGH_PEAK_MIN) begin
				high_tally_reg <= high_tally_reg + 1'b1; // [R10]
			end
		end
	end

	// counters survive frames; only reset clears them
	always_ff @(posedge mclk) begin
		if (reset) begin
			harm_ctr_reg <= lowrate_pkg::PERSIST_ZERO; // [R12] [R17]
			nonharm_ctr_reg <= lowrate_pkg::PERSIST_ZERO; // [R12] [R17]
		end else if (state_reg == st_decide) begin
			harm_ctr_reg <= harm_ctr_next; // [R17]
			nonharm_ctr_reg <= nonharm_ctr_next; // [R17]
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			mode_valid <= 1'b0;
			mode_transient <= 1'b0;
			mode_harmonic <= 1'b0;
			layout_sel <= lowrate_pkg::layout_nb;
		end else begin
			mode_valid <= bypass_reg || (state_reg == st_decide);
			if (bypass_reg) begin
				mode_transient <= transient_reg; // [R2] [R3]
				mode_harmonic <= 1'b0; // [R4]
				layout_sel <= layout_of(bw_reg); // [R14] [R15]
			end else if (state_reg == st_decide) begin
				mode_transient <= 1'b0; // [R3]
				mode_harmonic <= frame_harmonic; // [R3] [R5] [R13]
				layout_sel <= layout_of(bw_reg); // [R14] [R15]
			end
		end
	end

	assign classify_busy = (state_reg != st_idle);
	assign harmonic_persist_ctr = harm_ctr_reg;
	assign nonharmonic_persist_ctr = nonharm_ctr_reg;

	// transient frames lay the four short spectra end to end
	wire [lowrate_pkg::IDX_W-1:0] sub_len;
	wire [lowrate_pkg::IDX_W-1:0] sub_base;
	wire [lowrate_pkg::IDX_W-1:0] joined_index;

	assign sub_len = (layout_of(bw_reg) == lowrate_pkg::layout_nb) ?
		lowrate_pkg::SUB_LEN_NB :
		(layout_of(bw_reg) == lowrate_pkg::layout_wb) ?
		lowrate_pkg::SUB_LEN_WB : lowrate_pkg::SUB_LEN_SWB; // [R15]
	assign sub_base = lowrate_pkg::IDX_W'(sub_len *
		lowrate_pkg::IDX_W'(sub_index));
	assign joined_index = transient_reg ?
		lowrate_pkg::IDX_W'(sub_base +
		lowrate_pkg::IDX_W'(sub_coef_index)) :
		lowrate_pkg::IDX_W'(sub_coef_index); // [R16]

	always_ff @(posedge mclk) begin
		if (reset) begin
			concat_valid <= 1'b0;
			concat_index <= '0;
		end else begin
			concat_valid <= sub_valid;
			if (sub_valid) begin
				concat_index <= joined_index; // [R16]
			end
		end
	end

	// checks
	sequence bypass_frame_s;
		frame_start && !frame_transient &&
			!split_allowed(frame_bandwidth, frame_rate);
	endsequence

	sequence split_frame_s;
		frame_start && !frame_transient &&
			split_allowed(frame_bandwidth, frame_rate);
	endsequence

	narrow_normal_a: assert property (@(posedge mclk) disable iff (reset)
		bypass_frame_s ##1 !frame_start |=>
		mode_valid && !mode_harmonic && !mode_transient) // [R2] [R4]
		else $error("bypassed frame not reported as normal");
	transient_bit_a: assert property (@(posedge mclk) disable iff (reset)
		frame_start && frame_transient ##1 !frame_start |=>
		mode_valid && mode_transient && !mode_harmonic) // [R3]
		else $error("transient frame not flagged");
	counter_range_a: assert property (@(posedge mclk) disable iff (reset)
		harm_ctr_reg <= lowrate_pkg::PERSIST_MAX &&
		nonharm_ctr_reg <= lowrate_pkg::PERSIST_MAX) // [R12]
		else $error("persistence counter out of range");
	counter_hold_a: assert property (@(posedge mclk) disable iff (reset)
		state_reg != st_decide |=>
		$stable(harm_ctr_reg) && $stable(nonharm_ctr_reg)) // [R17]
		else $error("persistence counter moved outside decision");
	counter_step_a: assert property (@(posedge mclk) disable iff (reset)
		state_reg == st_decide && tally_hit && !harm_full |=>
		harm_ctr_reg == $past(harm_ctr_reg) + 1'b1) // [R11]
		else $error("harmonic counter missed its increment");
	tally_range_a: assert property (@(posedge mclk) disable iff (reset)
		low_tally_reg <= 4'h5 && high_tally_reg <= 4'h9) // [R9] [R10]
		else $error("sharpness tally beyond its band count");
	harm_rule_a: assert property (@(posedge mclk) disable iff (reset)
		state_reg == st_decide &&
		harm_ctr_next >= lowrate_pkg::PERSIST_HARM |=>
		mode_valid && mode_harmonic) // [R13]
		else $error("persistent harmonic frame not flagged");
	layout_fold_a: assert property (@(posedge mclk) disable iff (reset)
		mode_valid && (bw_reg == lowrate_pkg::bw_fb) |->
		layout_sel == lowrate_pkg::layout_swb) // [R14] [R15]
		else $error("fullband frame not on wideband-super layout");
	collect_quiet_a: assert property (@(posedge mclk) disable iff (reset)
		split_frame_s |=> !mode_valid [*8]) // [R17]
		else $error("decision made before bands were complete");
endmodule

// ==== coef_source.sv ====
// upstream transform stage model: streams one frame of classifier coefficients
`timescale 1ns/1ps

module coef_source (
	// clock
	input wire logic mclk,
	// stream control
	input wire logic start,
	input wire logic slow,
	input wire logic [13:0][15:0] peak_tab,
	input wire logic [13:0][15:0] bg_tab,
	// coefficient stream
	output logic coef_valid,
	output logic signed [15:0] coef_data,
	output logic busy
);
	int n = 0;
	int b;
	int pos;
	logic go;
	logic gap = 1'b0;
	logic [15:0] mag;

	initial begin
		coef_valid = 1'b0;
		coef_data = 16'sh0;
		busy = 1'b0;
	end

	// start is seen before the bench moves it, so no race at the edge
	always @(posedge mclk) begin
		go = start;
		#1;
		if (coef_valid)
			n++;
		if (go) begin
			busy = 1'b1;
			n = 0;
		end
		if (n == 448)
			busy = 1'b0;
		gap = slow & ~gap;
		if (busy && !gap) begin
			// bands 3 to 16 in order, 32 coefficients each
			b = n / 32;
			pos = n % 32;
			mag = (pos == (b * 5) % 32) ? peak_tab[b] : bg_tab[b];
			// alternating signs so only magnitudes may count
			coef_data = ((b + pos) % 2 == 1) ? -mag : mag;
			coef_valid = 1'b1;
		end else begin
			// a released line must not keep looking like data
			coef_data = ~coef_data;
			coef_valid = 1'b0;
		end
	end
endmodule

// ==== lowrate_mode_classifier_tb.sv ====
// self-checking bench for the low-rate mode classifier
`timescale 1ns/1ps

module lowrate_mode_classifier_tb;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic frame_start = 1'b0;
	logic [1:0] frame_bandwidth = 2'h0;
	logic [1:0] frame_rate = 2'h0;
	logic frame_transient = 1'b0;
	logic coef_valid;
	logic signed [15:0] coef_data;
	logic sub_valid = 1'b0;
	logic [1:0] sub_index = 2'h0;
	logic [7:0] sub_coef_index = 8'h00;
	logic mode_valid;
	logic mode_transient;
	logic mode_harmonic;
	logic [1:0] layout_sel;
	logic classify_busy;
	logic [3:0] harmonic_persist_ctr;
	logic [3:0] nonharmonic_persist_ctr;
	logic concat_valid;
	logic [9:0] concat_index;
	logic slow = 1'b0;
	logic src_busy;
	logic [13:0][15:0] peak_tab = '0;
	logic [13:0][15:0] bg_tab = '0;
	int n_mismatch = 0;
	int tests_run = 0;
	int harm_exp = 0;
	int nonharm_exp = 0;

	always #5 mclk = ~mclk;

	lowrate_mode_classifier i_dut (
		.mclk(mclk), .reset(reset), .frame_start(frame_start),
		.frame_bandwidth(frame_bandwidth), .frame_rate(frame_rate),
		.frame_transient(frame_transient), .coef_valid(coef_valid),
		.coef_data(coef_data), .sub_valid(sub_valid), .sub_index(sub_index),
		.sub_coef_index(sub_coef_index), .mode_valid(mode_valid),
		.mode_transient(mode_transient), .mode_harmonic(mode_harmonic),
		.layout_sel(layout_sel), .classify_busy(classify_busy),
		.harmonic_persist_ctr(harmonic_persist_ctr),
		.nonharmonic_persist_ctr(nonharmonic_persist_ctr),
		.concat_valid(concat_valid), .concat_index(concat_index)
	);

	coef_source i_src (
		.mclk(mclk), .start(frame_start), .slow(slow), .peak_tab(peak_tab),
		.bg_tab(bg_tab), .coef_valid(coef_valid), .coef_data(coef_data),
		.busy(src_busy)
	);

	task automatic step;
		@(posedge mclk);
		#1;
	endtask

	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("mismatches %0d of %0d checks", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic start_frame(input logic [1:0] bw, input logic [1:0] rt,
			input logic tr);
		frame_bandwidth = bw;
		frame_rate = rt;
		frame_transient = tr;
		frame_start = 1'b1;
		step;
		frame_start = 1'b0;
	endtask

	task automatic check_ctrs;
		check_val(16'(harmonic_persist_ctr), 16'(harm_exp));
		check_val(16'(nonharmonic_persist_ctr), 16'(nonharm_exp));
	endtask

	task automatic bypass_frame(input logic [1:0] bw, input logic [1:0] rt,
			input logic tr, input logic [1:0] lay);
		start_frame(bw, rt, tr);
		check_val(16'(mode_valid), 16'h0000);
		step;
		check_val(16'(mode_valid), 16'h0001);
		check_val(16'(mode_transient), 16'(tr));
		check_val(16'(mode_harmonic), 16'h0000);
		check_val(16'(layout_sel), 16'(lay));
		check_ctrs();
		step;
		check_val(16'(mode_valid), 16'h0000);
	endtask

	// sharpness worked out in real arithmetic, independent of the design
	function automatic void tallies(output int tl, output int th);
		real s;
		int sum;
		tl = 0;
		th = 0;
		for (int b = 0; b < 14; b++) begin
			sum = int'(peak_tab[b]) + 31 * int'(bg_tab[b]);
			s = (sum == 0) ? 0.0 : 32.0 * peak_tab[b] / sum;
			if (b < 5 && s > 4.5)
				tl++;
			if (b >= 5 && s > 3.6 && peak_tab[b] > 10)
				th++;
		end
	endfunction

	task automatic fill(input int lk, input int lp, input int lb,
			input int hk, input int hp, input int hb);
		for (int b = 0; b < 14; b++) begin
			if (b < 5) begin
				peak_tab[b] = 16'(b < lk ? lp : 0);
				bg_tab[b] = 16'(b < lk ? lb : 0);
			end else begin
				peak_tab[b] = 16'(hp);
				bg_tab[b] = 16'(b - 5 < hk ? hb : 3);
			end
		end
	endtask

	task automatic split_frame(input logic [1:0] bw, input logic [1:0] rt,
			input logic sl);
		int tl;
		int th;
		int k;
		logic hit;
		tallies(tl, th);
		hit = (tl + th >= 10) && (th > 5);
		if (hit) begin
			harm_exp = (harm_exp < 8) ? harm_exp + 1 : 8;
			nonharm_exp = (nonharm_exp > 0) ? nonharm_exp - 1 : 0;
		end else begin
			harm_exp = (harm_exp > 0) ? harm_exp - 1 : 0;
			nonharm_exp = (nonharm_exp < 8) ? nonharm_exp + 1 : 8;
		end
		slow = sl;
		start_frame(bw, rt, 1'b0);
		k = 0;
		do begin
			step;
			k++;
		end while (mode_valid !== 1'b1 && k < 1500);
		if (!sl)
			check_val(16'(k), 16'h01c2);
		check_val(16'(mode_valid), 16'h0001);
		check_val(16'(mode_transient), 16'h0000);
		check_val(16'(mode_harmonic),
			16'((nonharm_exp < 5 && hit) || harm_exp >= 5));
		check_val(16'(layout_sel), 16'h0002);
		check_ctrs();
		slow = 1'b0;
	endtask

	task automatic bypass_all;
		for (int i = 0; i < 32; i++)
			if (i[0] || i[4:3] < 2 || i[2:1] < 2)
				bypass_frame(i[4:3], i[2:1], i[0],
					i[4:3] == 3 ? 2'h2 : i[4:3]);
	endtask

	task automatic split_seq;
		fill(5, 6, 1, 9, 11, 2);
		for (int i = 0; i < 9; i++)
			split_frame(i[0] ? 2'h3 : 2'h2, i[1] ? 2'h3 : 2'h2, i == 2);
		fill(5, 5, 1, 9, 11, 2);
		split_frame(2'h2, 2'h2, 1'b0);
		fill(5, 6, 1, 5, 11, 2);
		split_frame(2'h2, 2'h3, 1'b0);
		fill(5, 6, 1, 9, 10, 0);
		split_frame(2'h3, 2'h2, 1'b0);
		fill(0, 0, 0, 9, 11, 2);
		split_frame(2'h2, 2'h2, 1'b0);
		bypass_frame(2'h2, 2'h2, 1'b1, 2'h2);
		fill(1, 6, 1, 9, 11, 2);
		split_frame(2'h2, 2'h2, 1'b0);
	endtask

	// a new frame_start mid-collection drops the frame, counters kept
	task automatic abandon_frame;
		int k;
		fill(5, 6, 1, 9, 11, 2);
		start_frame(2'h2, 2'h2, 1'b0);
		repeat (100) step;
		check_val(16'(classify_busy), 16'h0001);
		bypass_frame(2'h0, 2'h1, 1'b0, 2'h0);
		check_val(16'(classify_busy), 16'h0000);
		k = 0;
		while (src_busy && k < 600) begin
			step;
			k++;
		end
		repeat (2) step;
		check_val(16'(mode_valid), 16'h0000);
		check_ctrs();
	endtask

	// a mid-run reset must clear counters left nonzero by earlier frames
	task automatic reset_mid;
		reset = 1'b1;
		repeat (2) step;
		reset = 1'b0;
		harm_exp = 0;
		nonharm_exp = 0;
		check_ctrs();
		check_val(16'(classify_busy), 16'h0000);
	endtask

	task automatic concat_run(input logic [1:0] bw, input logic tr,
			input int len);
		bypass_frame(bw, tr ? 2'h2 : 2'h0, tr, bw == 2'h3 ? 2'h2 : bw);
		for (int s = 0; s < 4; s++) begin
			sub_valid = 1'b1;
			sub_index = 2'(s);
			sub_coef_index = 8'(s * 7 + 5);
			step;
			check_val(16'(concat_valid), 16'h0001);
			check_val(16'(concat_index),
				16'(tr ? s * len + s * 7 + 5 : s * 7 + 5));
		end
		sub_valid = 1'b0;
		step;
		check_val(16'(concat_valid), 16'h0000);
	endtask

	initial begin
		repeat (60000) @(posedge mclk);
		n_mismatch++;
		test_done();
	end

	initial begin
		repeat (16) step;
		reset = 1'b0;
		check_val(16'(mode_valid), 16'h0000);
		check_val(16'(mode_harmonic), 16'h0000);
		check_ctrs();
		bypass_all();
		split_seq();
		reset_mid();
		abandon_frame();
		concat_run(2'h0, 1'b1, 40);
		concat_run(2'h1, 1'b1, 80);
		concat_run(2'h2, 1'b1, 160);
		concat_run(2'h3, 1'b1, 160);
		concat_run(2'h2, 1'b0, 160);
		test_done();
	end
endmodule
